//--- src/reset_state_controller.sv
/*
 Reset state controller: combines reset sources, holds clocks and
 registers in their reset state, waits for oscillator settling, loads
 the program counter from the reset vector and then releases the core.
 Registers sit behind an APB slave. Assumes program memory answers
 vec_data combinationally for vec_addr, and all inputs are
 synchronous to clk.
*/
`timescale 1ns/1ns
module reset_state_controller
   import rst_pkg::*;
#(
   parameter int WDT_HOLD = WDT_HOLD_DEF,
   parameter int SETTLE_BASE = SETTLE_BASE_DEF,
   parameter int SETTLE_W = SETTLE_W_DEF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Reset sources and standby level
   input wire logic pin_rstn,
   input wire logic wdt_ovf,
   input wire logic poc_low,
   input wire logic lvi_low,
   input wire logic standby,
   // Reset vector fetch
   output logic [15:0] vec_addr,
   output logic vec_rd,
   input wire logic [7:0] vec_data,
   // Core side
   output logic [15:0] pc,
   output logic pc_valid,
   output logic wdt_reinit,
   output logic ram_retain,
   output clk_ctrl_s clk_ctrl,
   // Port and memory configuration
   output logic [7:0] port_out,
   output logic [7:0] port_dir,
   output logic [7:0] pullup_option,
   output logic [7:0] mem_size
);
   // Sequencer states
   typedef enum logic [4:0] {
      ST_HOLD = 5'b00001,
      ST_SETTLE = 5'b00010,
      ST_VEC_LO = 5'b00100,
      ST_VEC_HI = 5'b01000,
      ST_RUN = 5'b10000
   } seq_e;

   seq_e st_r, st_nxt;           // Sequencer state
   logic int_rst;                // Merged reset level
   logic wdt_active;             // Watchdog part of reset
   rst_src_s src;                // Latest reset causes
   logic [7:0] settle_stat;      // Settle counter steps
   logic settle_done;            // Selected wait elapsed
   logic [15:0] reg_r [NREGS];   // Register file
   logic [15:0] reg_nxt [NREGS];
   logic [15:0] pc_r, pc_nxt;
   logic [15:0] vaddr_r, vaddr_nxt;
   logic retain_r, retain_nxt;
   clk_ctrl_s clk_r, clk_nxt;
   logic [31:0] rd_r, rd_nxt;    // APB read data
   logic [IDX_W-1:0] idx;        // Decoded register index
   logic mapped;                 // Address hits a register
   logic wr_en;                  // Write takes effect this edge
   logic hold_regs;              // Registers forced to reset values

   // Source merge and watchdog stretch
   reset_combiner #(.WDT_HOLD(WDT_HOLD)) u_comb (
      .clk(clk),
      .rstn(rstn),
      .pin_rstn(pin_rstn),
      .wdt_ovf(wdt_ovf),
      .poc_low(poc_low),
      .lvi_low(lvi_low),
      .int_rst(int_rst),
      .wdt_active(wdt_active),
      .src(src)
   );

   // Settle wait runs on the fast oscillator once reset lifts
   settle_timer #(.CNT_W(SETTLE_W), .BASE(SETTLE_BASE)) u_settle (
      .clk(clk),
      .rstn(rstn),
      .clr(st_r == ST_HOLD),
      .sel(reg_r[IDX_SETTLE_SEL][SEL_W-1:0]),
      .status(settle_stat),
      .done(settle_done)
   );

   // Sequencer next state; any reset source wins over progress
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         ST_HOLD: if (!int_rst) st_nxt = ST_SETTLE;
         ST_SETTLE: if (settle_done) st_nxt = ST_VEC_LO;
         ST_VEC_LO: st_nxt = ST_VEC_HI;
         ST_VEC_HI: st_nxt = ST_RUN;
         ST_RUN: st_nxt = ST_RUN;
      endcase
      if (int_rst) begin
         st_nxt = ST_HOLD;
      end
   end

   // Vector fetch, PC load and standby capture
   always_comb begin
      pc_nxt = pc_r;
      vaddr_nxt = (st_nxt == ST_VEC_HI) ? VEC_ADDR_HI : VEC_ADDR_LO;
      retain_nxt = retain_r;
      // Low byte first, high byte second
      if (st_r == ST_VEC_LO) begin
         pc_nxt[7:0] = vec_data;
      end
      if (st_r == ST_VEC_HI) begin
         pc_nxt[15:8] = vec_data;
      end
      // Caught on the first reset cycle, before standby drops
      if (int_rst && st_r != ST_HOLD) begin
         retain_nxt = standby;
      end
   end

   // Sequencer and fetch registers
   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_r <= ST_HOLD;
         pc_r <= '0;
         vaddr_r <= VEC_ADDR_LO;
         retain_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         pc_r <= pc_nxt;
         vaddr_r <= vaddr_nxt;
         retain_r <= retain_nxt;
      end
   end

   // Clock controls follow the next state, so they line up with st_r
   always_comb begin
      clk_nxt.core_clk_en = (st_nxt == ST_RUN);
      clk_nxt.fast_osc_en = (st_nxt != ST_HOLD);
      clk_nxt.slow_osc_en = (st_nxt != ST_HOLD);
      // Crystal needs run state and a cleared stop bit
      clk_nxt.xtal_osc_en = (st_nxt == ST_RUN) &&
                            !reg_nxt[IDX_OSC_CTL][OSC_STOP_BIT];
      clk_nxt.xtal_port_mode = !clk_nxt.xtal_osc_en;
      clk_nxt.ext_clk_valid = (st_nxt == ST_RUN) &&
                              reg_nxt[IDX_CLK_MODE][CLK_SEL_BIT];
      // Mode bit clear means the internal fast oscillator
      clk_nxt.sel_fast_osc = (st_nxt != ST_RUN) ||
                             !reg_nxt[IDX_CLK_MODE][CLK_SEL_BIT];
   end

   // Clock control register
   always_ff @(posedge clk) begin
      if (!rstn) begin
         clk_r <= '{core_clk_en: 1'b0, fast_osc_en: 1'b0, slow_osc_en: 1'b0,
                    xtal_osc_en: 1'b0, xtal_port_mode: 1'b1,
                    ext_clk_valid: 1'b0, sel_fast_osc: 1'b1};
      end else begin
         clk_r <= clk_nxt;
      end
   end

   // APB decode; zero wait states, unmapped accesses and read-only writes error
   always_comb begin
      idx = paddr[6:2];
      mapped = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:7] == '0) &&
               (idx < IDX_W'(NREGS));
      wr_en = psel && penable && pwrite && mapped;
      pready = 1'b1;
      pslverr = psel && penable &&
                (!mapped || (pwrite && WR_MASK[idx] == 16'h0000));
      hold_regs = int_rst || (st_r != ST_RUN);
   end

   // Register file; held at reset values through reset and settle wait
   for (genvar g = 0; g < NREGS; g++) begin : g_reg
      always_comb begin
         reg_nxt[g] = reg_r[g];
         if (hold_regs) begin
            reg_nxt[g] = RST_VAL[g];
         end else if (wr_en && idx == IDX_W'(g)) begin
            reg_nxt[g] = pwdata[15:0] & WR_MASK[g];
         end
      end
      always_ff @(posedge clk) begin
         if (!rstn) begin
            reg_r[g] <= RST_VAL[g];
         end else begin
            reg_r[g] <= reg_nxt[g];
         end
      end
   end

   // Read data captured in the setup phase, stable through access
   always_comb begin
      rd_nxt = rd_r;
      if (psel && !penable) begin
         rd_nxt = '0;
         if (!mapped) begin
            rd_nxt = '0;
         end else if (idx == IDX_SETTLE_STAT) begin
            // Zero until the core runs
            rd_nxt[7:0] = (st_r == ST_RUN) ? settle_stat : 8'h00;
         end else if (idx == IDX_STATUS) begin
            rd_nxt[STAT_RUN] = (st_r == ST_RUN);
            rd_nxt[STAT_SRC+3:STAT_SRC] = src;
            rd_nxt[STAT_RETAIN] = retain_r;
         end else begin
            rd_nxt[15:0] = reg_r[idx];
         end
      end
   end

   // Read data register
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rd_r <= '0;
      end else begin
         rd_r <= rd_nxt;
      end
   end

   // Output drive
   assign prdata = rd_r;
   assign pc = pc_r;
   assign pc_valid = (st_r == ST_RUN);
   assign vec_addr = vaddr_r;
   assign vec_rd = (st_r == ST_VEC_LO) || (st_r == ST_VEC_HI);
   assign wdt_reinit = wdt_active;
   assign ram_retain = retain_r;
   assign clk_ctrl = clk_r;
   assign port_out = reg_r[IDX_PORT_LATCH][7:0];
   assign port_dir = reg_r[IDX_PORT_DIR][7:0];
   assign pullup_option = reg_r[IDX_PULLUP][7:0];
   assign mem_size = reg_r[IDX_MEM_SIZE][7:0];

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_wdt_reinit: assert property ($rose(wdt_ovf) |-> wdt_reinit [*4])
      else $error("watchdog not reinitialised during its reset");
   a_core_gated: assert property (int_rst |=> !clk_ctrl.core_clk_en)
      else $error("core clock running during reset");
   a_xtal_port: assert property (int_rst |=>
                  clk_ctrl.xtal_port_mode && !clk_ctrl.xtal_osc_en)
      else $error("crystal not halted in reset");
   a_ext_ignored: assert property (int_rst |=> !clk_ctrl.ext_clk_valid)
      else $error("external clock accepted in reset");
   a_vec_load: assert property (st_r == ST_VEC_HI |=>
                  pc == {$past(vec_data), $past(vec_data, 2)})
      else $error("program counter not loaded from vector");
   a_port_reset: assert property (st_r == ST_SETTLE |->
                  port_out == 8'h00 && port_dir == 8'hFF && pullup_option == 8'h00)
      else $error("port registers not at reset values");
   a_size_reset: assert property ($rose(pc_valid) |-> mem_size == 8'hCF)
      else $error("memory size switch not at reset value");
   a_clk_regs: assert property (st_r == ST_SETTLE |->
                  reg_r[IDX_SETTLE_SEL] == 16'h0005 && reg_r[IDX_OSC_CTL] == 16'h0080 &&
                  reg_r[IDX_CLK_MODE] == 16'h0000)
      else $error("clock registers not at reset values");
   a_timers_clr: assert property (st_r == ST_VEC_LO |->
                  reg_r[IDX_WT_COUNT] == 16'h0000 && reg_r[IDX_NT_LAST] == 16'h0000)
      else $error("timer registers not cleared");
   a_osc_stop: assert property (int_rst ##1 int_rst |->
                  !clk_ctrl.fast_osc_en && !clk_ctrl.slow_osc_en)
      else $error("oscillators running during reset");
   a_run_fast: assert property ($rose(clk_ctrl.core_clk_en) |-> clk_ctrl.sel_fast_osc)
      else $error("execution not started on fast oscillator");
   a_merge: assert property ((!pin_rstn || poc_low || lvi_low || wdt_ovf) |=>
                  st_r == ST_HOLD)
      else $error("reset source not merged");

   c_pin_reset: cover property (!pin_rstn ##1 pin_rstn ##[1:300] pc_valid);
   c_wdt_reset: cover property (pc_valid ##1 wdt_ovf ##[1:300] pc_valid);
   c_standby: cover property (standby && $rose(int_rst) ##1 ram_retain);
   c_apb_write: cover property (wr_en && st_r == ST_RUN);
endmodule

//--- src/rst_pkg.sv
/*
 Shared constants and carrier types for the reset state controller:
 register indices, reset values, write masks, field positions and
 the packed structs that carry clock controls and reset sources.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package rst_pkg;
   // Register file shape
   localparam int NREGS = 24;
   localparam int IDX_W = 5;
   localparam int ADDR_W = 12;
   // Register indices; byte address is index times four
   localparam logic [4:0] IDX_PORT_LATCH = 5'h00;
   localparam logic [4:0] IDX_PORT_DIR = 5'h01;
   localparam logic [4:0] IDX_PULLUP = 5'h02;
   localparam logic [4:0] IDX_MEM_SIZE = 5'h03;
   localparam logic [4:0] IDX_SETTLE_SEL = 5'h04;
   localparam logic [4:0] IDX_SETTLE_STAT = 5'h05;
   localparam logic [4:0] IDX_OSC_CTL = 5'h06;
   localparam logic [4:0] IDX_CLK_MODE = 5'h07;
   localparam logic [4:0] IDX_WT_COUNT = 5'h08;
   localparam logic [4:0] IDX_WT_CC_A = 5'h09;
   localparam logic [4:0] IDX_WT_CC_B = 5'h0A;
   localparam logic [4:0] IDX_WT_FIRST8 = 5'h0B;
   localparam logic [4:0] IDX_NT_LAST = 5'h16;
   localparam logic [4:0] IDX_STATUS = 5'h17;
   // Reset value per index (timer block from 08 to 16 is all zero)
   localparam logic [15:0] RST_VAL [NREGS] = '{
      16'h0000, 16'h00FF, 16'h0000, 16'h00CF, 16'h0005, 16'h0000,
      16'h0080, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
   // Writable bits per index; zero mask means read-only
   localparam logic [15:0] WR_MASK [NREGS] = '{
      16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h0000,
      16'h00FF, 16'h00FF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h00FF,
      16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF,
      16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h0000};
   // Field positions
   localparam int OSC_STOP_BIT = 7;
   localparam int CLK_SEL_BIT = 0;
   localparam int SEL_W = 3;
   localparam int STAT_RUN = 0;
   localparam int STAT_SRC = 1;
   localparam int STAT_RETAIN = 5;
   // Reset vector location
   localparam logic [15:0] VEC_ADDR_LO = 16'h0000;
   localparam logic [15:0] VEC_ADDR_HI = 16'h0001;
   // Default timing counts in clock cycles, and settle counter width in bits
   localparam int WDT_HOLD_DEF = 4;
   localparam int SETTLE_BASE_DEF = 1;
   localparam int SETTLE_W_DEF = 16;

   // Clock and oscillator controls
   typedef struct packed {
      logic core_clk_en;
      logic fast_osc_en;
      logic slow_osc_en;
      logic xtal_osc_en;
      logic xtal_port_mode;
      logic ext_clk_valid;
      logic sel_fast_osc;
   } clk_ctrl_s;

   // Reset sources, one bit each
   typedef struct packed {
      logic lvi;
      logic poc;
      logic wdt;
      logic pin;
   } rst_src_s;
endpackage

//--- src/reset_combiner.sv
/*
 Merges pin, watchdog and voltage detector resets into one level and
 records which sources caused the latest reset.
 Assumes all source inputs are synchronous to clk.
*/
`timescale 1ns/1ns
module reset_combiner
   import rst_pkg::*;
#(
   parameter int WDT_HOLD = WDT_HOLD_DEF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Sources
   input wire logic pin_rstn,
   input wire logic wdt_ovf,
   input wire logic poc_low,
   input wire logic lvi_low,
   // Results
   output logic int_rst,
   output logic wdt_active,
   output rst_src_s src
);
   localparam int CW = $clog2(WDT_HOLD + 1);

   initial begin
      if (WDT_HOLD < 1) $error("WDT_HOLD must be at least one");
   end

   logic [CW-1:0] cnt_r, cnt_nxt; // Watchdog reset stretch
   logic was_r, was_nxt;          // Reset seen last cycle
   rst_src_s src_r, src_nxt;      // Latched causes
   rst_src_s cur;                 // Causes this cycle

   // Current causes; a watchdog pulse is stretched to a full reset
   always_comb begin
      cur = '{lvi: lvi_low, poc: poc_low, wdt: wdt_ovf | (cnt_r != '0),
              pin: ~pin_rstn};
      int_rst = |cur;
      wdt_active = cur.wdt;
   end

   // Next stretch count and cause record
   always_comb begin
      cnt_nxt = cnt_r;
      if (wdt_ovf) begin
         cnt_nxt = CW'(WDT_HOLD);
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - CW'(1);
      end
      was_nxt = int_rst;
      src_nxt = src_r;
      // New reset replaces the record, an ongoing one accumulates
      if (int_rst) begin
         src_nxt = was_r ? rst_src_s'(src_r | cur) : cur;
      end
   end

   // State registers
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cnt_r <= '0;
         was_r <= 1'b0;
         src_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
         was_r <= was_nxt;
         src_r <= src_nxt;
      end
   end

   assign src = src_r;
endmodule

//--- src/settle_timer.sv
/*
 Oscillation settle counter: counts from clear, shows one status bit
 per doubling step and flags the end of the selected wait.
 Assumes clr is held while oscillators are stopped.
*/
`timescale 1ns/1ns
module settle_timer
   import rst_pkg::*;
#(
   parameter int CNT_W = SETTLE_W_DEF,
   parameter int BASE = SETTLE_BASE_DEF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Control
   input wire logic clr,
   input wire logic [SEL_W-1:0] sel,
   // Results
   output logic [7:0] status,
   output logic done
);
   initial begin
      if (BASE < 1 || (BASE << 7) >= (1 << CNT_W))
         $error("settle_timer BASE does not fit CNT_W");
   end

   logic [CNT_W-1:0] cnt_r, cnt_nxt; // Cycles since clear

   // Saturating count, so status never wraps back to zero
   always_comb begin
      cnt_nxt = cnt_r;
      if (clr) begin
         cnt_nxt = '0;
      end else if (cnt_r != '1) begin
         cnt_nxt = cnt_r + CNT_W'(1);
      end
   end

   // Counter register
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // One threshold per status bit
   for (genvar g = 0; g < 8; g++) begin : g_stat
      assign status[g] = cnt_r >= CNT_W'(BASE << g);
   end
   assign done = status[sel];
endmodule

//--- sim/reset_source_model.sv
/*
 Far-side model: reset pin driver, watchdog and voltage detector
 sources, and the program memory that answers the vector fetch.
 Assumes one clock shared with the controller; tasks run from the bench.
*/
`timescale 1ns/1ns
module reset_source_model #(
   parameter logic [15:0] VEC = 16'h1234
) (
   // Clock
   input wire logic clk,
   // Vector fetch
   input wire logic [15:0] vec_addr,
   input wire logic vec_rd,
   output logic [7:0] vec_data,
   // Reset sources
   output logic pin_rstn,
   output logic wdt_ovf,
   output logic poc_low,
   output logic lvi_low
);
   // Filler that changes every cycle, so a stale byte never looks valid
   logic [7:0] junk_r = 8'h5A;
   int hold;

   // Filler pattern
   always @(posedge clk) begin
      junk_r <= ~junk_r + 8'h01;
   end

   // Program memory, answers only while the fetch is requested
   always_comb begin
      vec_data = junk_r;
      if (vec_rd && vec_addr == 16'h0000) begin
         vec_data = VEC[7:0];
      end else if (vec_rd && vec_addr == 16'h0001) begin
         vec_data = VEC[15:8];
      end
   end

   // Idle sources
   initial begin
      pin_rstn = 1'b1;
      wdt_ovf = 1'b0;
      poc_low = 1'b0;
      lvi_low = 1'b0;
   end

   // Raise one source for n cycles: 0 pin, 1 watchdog, 2 poc, 3 lvi
   task automatic fire(input int which, input int n);
      hold = n;
      // Pin never shorter than 10 us, 1250 cycles at 8 ns
      if (which == 0 && hold < 1250) begin
         hold = 1250;
      end
      @(posedge clk);
      case (which)
         0: pin_rstn <= 1'b0;
         1: wdt_ovf <= 1'b1;
         2: poc_low <= 1'b1;
         default: lvi_low <= 1'b1;
      endcase
      repeat (hold) @(posedge clk);
      pin_rstn <= 1'b1;
      wdt_ovf <= 1'b0;
      poc_low <= 1'b0;
      lvi_low <= 1'b0;
   endtask
endmodule

//--- sim/tb.sv
/*
 Self-checking bench for the reset state controller: APB master,
 reset source scenarios, register reset values and refusals.
 Assumes the far-side model and a 125 MHz clock.
*/
`timescale 1ns/1ns
module tb;
   import rst_pkg::*;
   localparam logic [15:0] VEC = 16'h1234;
   // Reset values of the first eight registers, timers are zero
   localparam logic [7:0] EXP_RST [8] = '{8'h00, 8'hFF, 8'h00, 8'hCF,
      8'h05, 8'h00, 8'h80, 8'h00};
   logic clk, rstn, psel, penable, pwrite, standby;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, err;
   logic pin_rstn, wdt_ovf, poc_low, lvi_low, vec_rd, pc_valid;
   logic wdt_reinit, ram_retain;
   logic [15:0] vec_addr, pc;
   logic [7:0] vec_data, port_out, port_dir, pullup_option, mem_size;
   clk_ctrl_s clk_ctrl;
   int errors, checks_done;

   reset_state_controller u_reset_state_controller (.clk(clk), .rstn(rstn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_rstn(pin_rstn), .wdt_ovf(wdt_ovf), .poc_low(poc_low),
      .lvi_low(lvi_low), .standby(standby), .vec_addr(vec_addr),
      .vec_rd(vec_rd), .vec_data(vec_data), .pc(pc), .pc_valid(pc_valid),
      .wdt_reinit(wdt_reinit), .ram_retain(ram_retain), .clk_ctrl(clk_ctrl),
      .port_out(port_out), .port_dir(port_dir), .pullup_option(pullup_option),
      .mem_size(mem_size));
   reset_source_model #(.VEC(VEC)) u_reset_source_model (.clk(clk),
      .vec_addr(vec_addr), .vec_rd(vec_rd), .vec_data(vec_data),
      .pin_rstn(pin_rstn), .wdt_ovf(wdt_ovf), .poc_low(poc_low),
      .lvi_low(lvi_low));

   // Free-running 8 ns clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Verdict and stop, the only exit
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Compare a data word
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Compare a single flag
   task automatic chk_bit(input logic got, input logic exp);
      chk_val({31'h0, got}, {31'h0, exp});
   endtask

   // One APB transfer; the slave decides when it answers
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         errors++;
         end_sim();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Byte address of a register index
   function automatic logic [ADDR_W-1:0] ba(input int idx);
      return ADDR_W'(idx * 4);
   endfunction

   // Bounded wait for the core to be released
   task automatic wait_run();
      int n;
      for (n = 0; n < 300 && pc_valid !== 1'b1; n++) begin
         @(negedge clk);
      end
      if (n >= 300) begin
         errors++;
         end_sim();
      end
   endtask

   // All registers but the live settle status and the status word against reset values
   task automatic check_regs();
      for (int i = 0; i < 23; i++) begin
         if (i != 5) begin
            apb(1'b0, ba(i), 32'h0);
            chk_val(rd, {24'h0, (i < 8) ? EXP_RST[i] : 8'h00});
         end
      end
      chk_val({port_out, port_dir, pullup_option, mem_size}, 32'h00FF00CF);
   endtask

   // Reset release: vector, clock choice and reset values
   task automatic t_defaults();
      wait_run();
      chk_val({16'h0, pc}, {16'h0, VEC});
      chk_bit(clk_ctrl.core_clk_en, 1'b1);
      chk_bit(clk_ctrl.sel_fast_osc, 1'b1);
      // Oscillators run, crystal still stopped, fast oscillator selected
      chk_val({25'h0, clk_ctrl}, 32'h75);
      check_regs();
      $display("test defaults done");
   endtask

   // Every source, plus pin reset from standby (case 4)
   task automatic t_sources();
      int src;
      for (int k = 0; k < 5; k++) begin
         src = (k == 4) ? 0 : k;
         // Dirty every writable register first
         for (int i = 0; i < 23; i++) begin
            apb(1'b1, ba(i), 32'h0000A5A5);
         end
         apb(1'b0, ba(0), 32'h0);
         chk_val(rd, 32'h000000A5);
         // Dirty mode bits: crystal stop set, external clock chosen
         chk_val({25'h0, clk_ctrl}, 32'h76);
         standby <= (k == 4);
         fork
            u_reset_source_model.fire(src, 3);
            begin
               repeat (4) @(negedge clk);
               chk_val({25'h0, clk_ctrl}, 32'h05);
               chk_bit(wdt_reinit, src == 1);
               chk_bit(pc_valid, 1'b0);
               apb(1'b0, ba(5), 32'h0);
               chk_val(rd, 32'h0);
               // Write outside run is dropped without an error
               apb(1'b1, ba(0), 32'h00000033);
               chk_bit(err, 1'b0);
            end
         join
         standby <= 1'b0;
         wait_run();
         chk_val({16'h0, pc}, {16'h0, VEC});
         chk_bit(ram_retain, k == 4);
         apb(1'b0, ba(23), 32'h0);
         chk_val({27'h0, rd[5:1]}, (k == 4) ? 32'h11 : 32'h1 << src);
         check_regs();
      end
      $display("test sources done");
   endtask

   // Refused accesses, wide pairing and the variant size code
   task automatic t_refuse();
      apb(1'b0, ba(24), 32'h0);
      chk_val({rd[30:0], err}, 32'h1);
      apb(1'b0, 12'h002, 32'h0);
      chk_bit(err, 1'b1);
      apb(1'b1, ba(5), 32'h000000FF);
      chk_bit(err, 1'b1);
      apb(1'b1, ba(23), 32'h000000FF);
      chk_bit(err, 1'b1);
      apb(1'b1, ba(8), 32'hFFFFFFFF);
      apb(1'b0, ba(8), 32'h0);
      chk_val(rd, 32'h0000FFFF);
      // Clearing the stop bit starts the crystal and frees its pins
      apb(1'b1, ba(6), 32'h00000000);
      apb(1'b0, ba(6), 32'h0);
      chk_val({25'h0, clk_ctrl}, 32'h79);
      apb(1'b1, ba(3), 32'h000000C8);
      apb(1'b0, ba(3), 32'h0);
      chk_val({rd[30:0], err}, 32'h190);
      $display("test refuse done");
   endtask

   // Main sequence
   initial begin
      errors = 0;
      checks_done = 0;
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      standby = 1'b0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      t_defaults();
      t_sources();
      t_refuse();
      end_sim();
   end
endmodule
